// File: src/dmw_watchdog.sv
module dmw_watchdog
   import dmw_pkg::*;
#(
   parameter int unsigned LONG_CYCLES   = 32'(LONG_CYC),
   parameter int unsigned NORMAL_CYCLES = 32'(NORMAL_CYC),
   parameter int unsigned RESET_CYCLES  = 32'(RESET_CYC),
   parameter int unsigned PF_CYCLES     = PF_DELAY_CYC
) (
   input  wire logic core_clk,           // Timebase, 25 MHz
   input  wire logic rstn,               // Async reset, active low
   input  wire logic watchdog_kick_in,   // Kick level from processor
   input  wire logic kick_open_in,       // High when kick pin is unconnected
   input  wire logic powerfail_sense_in, // Comparator: high when above reference
   output logic      wd_reset_q,         // Watchdog reset pulse, active high
   output logic      powerfail_flag_n    // Power-fail flag, active low
);
   dmw_state_t  state_q, state_d;
   // 32 bits hold the long window at the full timebase
   logic [31:0] cnt_q, cnt_d;
   logic        kick_q, kick_d;
   logic        rst_d;
   logic        edge_w;
   logic [15:0] pf_cnt_q, pf_cnt_d;
   logic        pf_q, pf_d;

   // Either polarity of transition counts; a pulse that falls between two core_clk edges is missed
   assign edge_w = (watchdog_kick_in != kick_q);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 32'h1;
      kick_d  = watchdog_kick_in;
      rst_d   = 1'b0;
      if (kick_open_in) begin
         // Held in long window so reconnecting starts safely
         state_d = DMW_LONG;
         cnt_d   = 32'h0;
      end else begin
         unique case (state_q)
            DMW_LONG: begin
               if (edge_w) begin
                  state_d = DMW_NORMAL;
                  cnt_d   = 32'h0;
               end else if (cnt_q >= LONG_CYCLES - 1) begin
                  // A boot that never kicks is taken as hung and reset too
                  state_d = DMW_PULSE;
                  cnt_d   = 32'h0;
                  rst_d   = 1'b1;
               end
            end
            DMW_NORMAL: begin
               if (edge_w) begin
                  cnt_d = 32'h0;
               end else if (cnt_q >= NORMAL_CYCLES - 1) begin
                  state_d = DMW_PULSE;
                  cnt_d   = 32'h0;
                  rst_d   = 1'b1;
               end
            end
            DMW_PULSE: begin
               // Kicks are ignored until the pulse has run its full length
               rst_d = 1'b1;
               if (cnt_q >= RESET_CYCLES - 1) begin
                  state_d = DMW_LONG;
                  cnt_d   = 32'h0;
                  rst_d   = 1'b0;
               end
            end
            default: begin
               state_d = DMW_LONG;
               cnt_d   = 32'h0;
            end
         endcase
      end
   end

   // Output rests high in reset so the host is held while the block restarts
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q    <= DMW_LONG;
         cnt_q      <= 32'h0;
         kick_q     <= 1'b0;
         wd_reset_q <= RST_OUT_RESET;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         kick_q     <= kick_d;
         wd_reset_q <= rst_d;
      end
   end

   // Falling sense is delayed to mimic comparator lag; recovery is immediate
   always_comb begin
      pf_d     = pf_q;
      pf_cnt_d = 16'h0;
      if (powerfail_sense_in) begin
         pf_d = 1'b1;
      end else if (pf_q) begin
         pf_cnt_d = pf_cnt_q + 16'h1;
         if (pf_cnt_q >= 16'(PF_CYCLES - 1)) begin
            pf_d     = 1'b0;
            pf_cnt_d = 16'h0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pf_q     <= PF_FLAG_RESET;
         pf_cnt_q <= 16'h0;
      end else begin
         pf_q     <= pf_d;
         pf_cnt_q <= pf_cnt_d;
      end
   end

   assign powerfail_flag_n = pf_q;

   property p_normal_timeout;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_NORMAL && cnt_q == NORMAL_CYCLES - 1 && !edge_w && !kick_open_in)
      |=> wd_reset_q && state_q == DMW_PULSE;
   endproperty
   a_normal_timeout: assert property (p_normal_timeout) else $error("missed timeout");

   property p_first_edge;
      @(posedge core_clk) disable iff (!rstn)
      (rstn && state_q == DMW_LONG && edge_w && !kick_open_in)
      |=> state_q == DMW_NORMAL && cnt_q == 0;
   endproperty
   a_first_edge: assert property (p_first_edge) else $error("no normal mode");

   property p_edge_restart;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_NORMAL && edge_w && !kick_open_in) |=> cnt_q == 0 && !wd_reset_q;
   endproperty
   a_edge_restart: assert property (p_edge_restart) else $error("edge ignored");

   property p_disabled;
      @(posedge core_clk) disable iff (!rstn)
      (rstn && kick_open_in) |=> state_q == DMW_LONG && !wd_reset_q;
   endproperty
   a_disabled: assert property (p_disabled) else $error("watchdog not off");

   property p_pf_low;
      @(posedge core_clk) disable iff (!rstn)
      (!powerfail_sense_in)[*2] |-> ##1 !(pf_q && $past(pf_q) && pf_cnt_q == 0);
   endproperty
   a_pf_low: assert property (p_pf_low) else $error("flag stuck high");

   property p_pf_delay;
      @(posedge core_clk) disable iff (!rstn)
      (pf_q && !powerfail_sense_in && pf_cnt_q == 0) |-> ##[1:60] !pf_q || powerfail_sense_in;
   endproperty
   a_pf_delay: assert property (p_pf_delay) else $error("flag too slow");

   property p_pf_release;
      @(posedge core_clk) disable iff (!rstn)
      (rstn && powerfail_sense_in) |=> pf_q;
   endproperty
   a_pf_release: assert property (p_pf_release) else $error("flag release late");

   property p_pulse_end;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_PULSE && !kick_open_in && cnt_q == RESET_CYCLES - 1)
      |=> state_q == DMW_LONG && !wd_reset_q;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("no long window");

   // Several antecedents also test the sampled rstn: at the release edge the flops still
   // hold their reset values, so a check launched there would judge stale outputs
   property p_long_hold;
      @(posedge core_clk) disable iff (!rstn)
      (rstn && state_q == DMW_LONG && !edge_w && !kick_open_in && cnt_q < LONG_CYCLES - 1)
      |=> state_q == DMW_LONG && !wd_reset_q;
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long window cut");

   property p_long_timeout;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_LONG && cnt_q == LONG_CYCLES - 1 && !edge_w && !kick_open_in)
      |=> wd_reset_q && state_q == DMW_PULSE;
   endproperty
   a_long_timeout: assert property (p_long_timeout) else $error("long expiry lost");

   property p_normal_hold;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_NORMAL && !edge_w && !kick_open_in && cnt_q < NORMAL_CYCLES - 1)
      |=> state_q == DMW_NORMAL && !wd_reset_q;
   endproperty
   a_normal_hold: assert property (p_normal_hold) else $error("normal too short");

   property p_pulse_hold;
      @(posedge core_clk) disable iff (!rstn)
      (state_q == DMW_PULSE && !kick_open_in && cnt_q < RESET_CYCLES - 1)
      |=> state_q == DMW_PULSE && wd_reset_q;
   endproperty
   a_pulse_hold: assert property (p_pulse_hold) else $error("pulse too short");

   property p_quiet;
      @(posedge core_clk) disable iff (!rstn)
      (rstn && $past(rstn) && state_q != DMW_PULSE) |-> !wd_reset_q;
   endproperty
   a_quiet: assert property (p_quiet) else $error("reset outside pulse");

   property p_pf_hold;
      @(posedge core_clk) disable iff (!rstn)
      (pf_q && !powerfail_sense_in && pf_cnt_q < 16'(PF_CYCLES - 1)) |=> pf_q;
   endproperty
   a_pf_hold: assert property (p_pf_hold) else $error("flag fell early");

   property p_pf_fall;
      @(posedge core_clk) disable iff (!rstn)
      (pf_q && !powerfail_sense_in && pf_cnt_q == 16'(PF_CYCLES - 1)) |=> !pf_q;
   endproperty
   a_pf_fall: assert property (p_pf_fall) else $error("flag did not fall");

   // Cover points for the main scenarios

   c_normal: cover property (@(posedge core_clk) state_q == DMW_NORMAL);
   c_pulse:  cover property (@(posedge core_clk) state_q == DMW_PULSE);
   c_pf:     cover property (@(posedge core_clk) $fell(pf_q));
   c_open:   cover property (@(posedge core_clk) kick_open_in && state_q == DMW_LONG);
   c_pf_up:  cover property (@(posedge core_clk) $rose(pf_q));
endmodule

// File: shared/dmw_pkg.sv
// How it works
// - First kick in long window starts normal timeout
// - Missed normal window gives reset pulse
// - Rising and falling kick edges both count
// - Unconnected kick input disables the watchdog
// - Flag follows comparator within about two microseconds
// - Long initial window after every reset event
// - Flag releases at once, no reset timeout
package dmw_pkg;
   localparam int unsigned CLK_HZ       = 25000000;
   localparam int unsigned LONG_MS      = 35000;
   localparam int unsigned NORMAL_MS    = 1120;
   localparam int unsigned RESET_MS     = 140;
   localparam int unsigned PF_DELAY_NS  = 2000;
   localparam int unsigned CLK_NS       = 1000000000 / CLK_HZ;
   localparam longint unsigned LONG_CYC   = longint'(LONG_MS) * (CLK_HZ / 1000);
   localparam longint unsigned NORMAL_CYC = longint'(NORMAL_MS) * (CLK_HZ / 1000);
   localparam longint unsigned RESET_CYC  = longint'(RESET_MS) * (CLK_HZ / 1000);
   localparam int unsigned PF_DELAY_CYC = PF_DELAY_NS / CLK_NS;
   localparam logic        RST_OUT_RESET = 1'b1;
   localparam logic        PF_FLAG_RESET = 1'b0;

   typedef enum logic [2:0] {
      DMW_LONG   = 3'b001,
      DMW_NORMAL = 3'b010,
      DMW_PULSE  = 3'b100
   } dmw_state_t;
endpackage

// File: verification/dmw_cpu_model.sv
module dmw_cpu_model (
   input  wire logic core_clk,         // Timebase
   input  wire logic wd_reset_q,       // Reset from the supervisor
   input  wire logic kick_cmd,         // Move the kick level once
   output logic      watchdog_kick_in  // Kick level to the supervisor
);
   timeunit 1ns;
   timeprecision 1ns;
   // Held in reset the processor parks the pin low; software moves the level
   always @(posedge core_clk) begin
      if (wd_reset_q)
         watchdog_kick_in <= 1'b0;
      else if (kick_cmd)
         watchdog_kick_in <= ~watchdog_kick_in;
   end
endmodule

// File: verification/dmw_watchdog_tb.sv
module dmw_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dmw_pkg::*;
   localparam int LC = 40;
   localparam int NC = 10;
   localparam int RC = 5;
   localparam int PC = 3;
   logic core_clk, rstn, kick_open_in, powerfail_sense_in, kick_cmd;
   logic watchdog_kick_in, wd_reset_q, powerfail_flag_n;
   int   n_mismatch = 0;
   int   num_checks = 0;
   int   n;
   dmw_watchdog #(.LONG_CYCLES(LC), .NORMAL_CYCLES(NC), .RESET_CYCLES(RC), .PF_CYCLES(PC))
   u_dmw_watchdog (.core_clk(core_clk), .rstn(rstn), .watchdog_kick_in(watchdog_kick_in),
      .kick_open_in(kick_open_in), .powerfail_sense_in(powerfail_sense_in),
      .wd_reset_q(wd_reset_q), .powerfail_flag_n(powerfail_flag_n));
   dmw_cpu_model u_dmw_cpu_model (.core_clk(core_clk), .wd_reset_q(wd_reset_q),
      .kick_cmd(kick_cmd), .watchdog_kick_in(watchdog_kick_in));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   // Counts edges until the chosen output reaches v; a spent bound ends the run
   task wait_for(input bit pf, input logic v, input int lim);
      n = 0;
      while ((pf ? powerfail_flag_n : wd_reset_q) !== v) begin
         if (n == lim) begin
            n_mismatch++;
            close_out();
         end
         tick();
         n++;
      end
   endtask
   task kick;
      @(posedge core_clk);
      kick_cmd <= 1'b1;
      @(posedge core_clk);
      kick_cmd <= 1'b0;
      #1;
   endtask
   task t_long;
      tick();
      check("reset release", wd_reset_q, 0);
      check("flag after reset", powerfail_flag_n, 1);
      wait_for(0, 1'b1, LC + 10);
      // The first active edge already counts, so LC - 1 edges remain
      check("long window", n, LC - 1);
      wait_for(0, 1'b0, RC + 3);
      check("pulse length", n, RC);
   endtask
   task t_normal;
      kick();
      wait_for(0, 1'b1, NC + 10);
      // The new level is seen one edge after the task returns
      check("normal timeout", n, NC + 1);
      wait_for(0, 1'b0, RC + 3);
   endtask
   task t_edges;
      kick();
      repeat (6) begin
         repeat (NC - 4) tick();
         kick();
         check("both edges kick", wd_reset_q, 0);
      end
      wait_for(0, 1'b1, NC + 10);
      wait_for(0, 1'b0, RC + 3);
   endtask
   task t_open;
      logic seen;
      seen = 1'b0;
      @(posedge core_clk);
      kick_open_in <= 1'b1;
      repeat (LC + 20) begin
         tick();
         seen = seen | wd_reset_q;
      end
      check("open pin disables", seen, 0);
      @(posedge core_clk);
      kick_open_in <= 1'b0;
   endtask
   task t_pf;
      @(posedge core_clk);
      powerfail_sense_in <= 1'b0;
      #1;
      wait_for(1, 1'b0, PC + 5);
      check("flag fall delay", n, PC);
      @(posedge core_clk);
      powerfail_sense_in <= 1'b1;
      #1;
      wait_for(1, 1'b1, 4);
      check("flag release", n, 1);
   endtask
   // A reset event on the edge that first sees the kick must bring back the long window
   task t_rerst;
      kick();
      @(posedge core_clk);
      rstn <= 1'b0;
      tick();
      check("reset asserts", wd_reset_q, 1);
      @(posedge core_clk);
      rstn <= 1'b1;
      tick();
      check("release again", wd_reset_q, 0);
      wait_for(0, 1'b1, LC + 10);
      check("long after reset", n, LC - 1);
      wait_for(0, 1'b0, RC + 3);
      check("pulse after reset", n, RC);
   endtask
   initial begin
      rstn = 1'b0;
      kick_open_in = 1'b0;
      powerfail_sense_in = 1'b1;
      kick_cmd = 1'b0;
      repeat (12) @(posedge core_clk);
      check("reset holds output", wd_reset_q, 1);
      rstn <= 1'b1;
      t_long();
      t_normal();
      t_edges();
      t_open();
      t_pf();
      t_rerst();
      close_out();
   end
endmodule
